// File: design/fpw_flash_ctrl.sv
// Flash control register, security gating and paging window front end.
// Assumes the CPU issues at most one read or write per cycle and that the
// memory system answers reads for addresses forwarded on mem_req_q.
//
// Behaviour
// RL1: The high-voltage enable at bit 3 can only be set while program or mass-erase select is 1 and a flash write has latched the target.
// RL2: Bit 2 of the flash control register is a read/write mass-erase select.
// RL3: Bit 0 of the flash control register is a read/write program select.
// RL4: Program and mass-erase selects are never both 1, not even from one write asking for both.
// RL5: While security is engaged, writes to the program select bit are ignored.
// RL6: Direct addresses $00C0 to $00FF form a 64-byte window onto the page chosen by the page selector.
// RL7: The page selector supplies address bits 13 to 6 of window accesses, the window offset bits 5 to 0.
// RL8: Page $08 reaches the high-page registers at $0200, pages $40 to $FF reach flash from $1000.
// RL9: With page $00, window offsets $C0 to $CE reach RAM $0000 to $000E and $CF reaches the index register.
// RL10: The indirect data register sits only at $000E and reaches RAM $000E when the index holds $0E or $CE on page $00.
// RL11: Address $CE on page $00 returns RAM $000E while direct $000E returns the indirect data.
// RL12: Page $00 maps the window onto addresses $00 to $3F.
// RL13: Software programs flash one 64-byte aligned row at a time through the window.
// RL14: The security state bit loaded at reset means disengaged when 1 and engaged when 0.
`timescale 1ns/1ps
module fpw_flash_ctrl
  import fpw_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_W
)
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [13:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic [7:0]  index_value,
  input  wire logic        security_state_bit,
  output fpw_mem_req_t     mem_req_q,
  output logic [7:0]       reg_rdata_q,
  output logic             reg_rvalid_q,
  output logic             row_program_select_q,
  output logic             mass_erase_select_q,
  output logic             array_high_voltage_on_q,
  output logic             secured_q
);

  initial begin
    if (ADDR_BITS != ADDR_W) begin
      $error("fpw_flash_ctrl serves only a 14-bit address map");
    end
  end

  logic [13:0]  phys_addr;
  logic         via_window;
  logic [7:0]   page_sel_q, page_sel_d;
  logic         pgm_d, mass_d, hv_d, armed_q, armed_d;
  logic         secured_d;
  logic         hit_flash_control, hit_psel, hit_flash;
  logic         pgm_req, mass_req;
  fpw_mem_req_t mem_req_d;
  logic [7:0]   rdata_d;
  logic         rvalid_d;

  fpw_window_map u_map (
    .cpu_addr   (cpu_addr),
    .page_sel   (page_sel_q),
    .index_value(index_value),
    .phys_addr  (phys_addr),
    .via_window (via_window)
  );

  assign hit_flash_control  = (phys_addr == FLASH_CONTROL_ADDR);
  assign hit_psel  = (phys_addr == PAGE_SELECTOR_ADDR);
  assign hit_flash = (phys_addr >= FLASH_BASE);

  always_comb begin
    // Security copy is taken while reset is held
    secured_d = reset ? ~security_state_bit : secured_q;  // see RL14
    page_sel_d = page_sel_q;
    pgm_d      = row_program_select_q;
    mass_d     = mass_erase_select_q;
    hv_d       = array_high_voltage_on_q;
    armed_d    = armed_q;
    pgm_req    = cpu_wdata[PROG_SEL_BIT];
    mass_req   = cpu_wdata[MASS_SEL_BIT];
    if (cpu_wr && hit_psel) begin
      page_sel_d = cpu_wdata;
    end
    if (cpu_wr && hit_flash_control) begin
      // Secured parts keep the old program select
      if (secured_q) begin  // see RL5
        pgm_req = row_program_select_q;
      end
      // Asking for both keeps a held select, else only mass erase
      pgm_d  = pgm_req & (~mass_req | row_program_select_q);  // see RL3, RL4
      mass_d = mass_req & ~pgm_d;  // see RL2, RL4
      // ARRAY_HIGH_VOLTAGE_ON judged on the selects held before this write
      hv_d = cpu_wdata[HV_ON_BIT] &
             (array_high_voltage_on_q |
              ((row_program_select_q | mass_erase_select_q) & armed_q));
      // see RL1
    end
    // Latching write into flash arms the high-voltage step
    if (cpu_wr && hit_flash &&
        (row_program_select_q | mass_erase_select_q)) begin  // see RL1
      armed_d = 1'b1;
    end
    if (!pgm_d && !mass_d) begin
      armed_d = 1'b0;
    end
  end

  always_comb begin
    mem_req_d       = '0;
    mem_req_d.addr  = phys_addr;  // see RL9, RL11
    mem_req_d.wdata = cpu_wdata;
    // Own registers are not forwarded so memory never double-answers
    mem_req_d.wr = cpu_wr & ~hit_flash_control & ~hit_psel;
    mem_req_d.rd = cpu_rd & ~hit_flash_control & ~hit_psel;
    rvalid_d     = cpu_rd & (hit_flash_control | hit_psel);
    rdata_d      = 8'h00;
    if (cpu_rd && hit_flash_control) begin
      rdata_d[HV_ON_BIT]    = array_high_voltage_on_q;
      rdata_d[MASS_SEL_BIT] = mass_erase_select_q;
      rdata_d[PROG_SEL_BIT] = row_program_select_q;
    end else if (cpu_rd && hit_psel) begin
      rdata_d = page_sel_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      page_sel_q              <= PAGE_SELECTOR_RST;
      row_program_select_q    <= FLASH_CONTROL_RST[PROG_SEL_BIT];
      mass_erase_select_q     <= FLASH_CONTROL_RST[MASS_SEL_BIT];
      array_high_voltage_on_q <= FLASH_CONTROL_RST[HV_ON_BIT];
      armed_q                 <= 1'b0;
      mem_req_q               <= '0;
      reg_rdata_q             <= 8'h00;
      reg_rvalid_q            <= 1'b0;
    end else begin
      page_sel_q              <= page_sel_d;
      row_program_select_q    <= pgm_d;
      mass_erase_select_q     <= mass_d;
      array_high_voltage_on_q <= hv_d;
      armed_q                 <= armed_d;
      mem_req_q               <= mem_req_d;
      reg_rdata_q             <= rdata_d;
      reg_rvalid_q            <= rvalid_d;
    end
    secured_q <= secured_d;
  end

  // Checks
  a_select_interlock: assert property (  // see RL4
    @(posedge mclk) disable iff (reset)
    !(row_program_select_q && mass_erase_select_q))
    else $error("program and mass erase selected together");

  a_hv_needs_select: assert property (  // see RL1
    @(posedge mclk) disable iff (reset)
    $rose(array_high_voltage_on_q) |->
      $past(row_program_select_q | mass_erase_select_q) && $past(armed_q))
    else $error("high voltage set without armed select");

  a_secure_pgm_hold: assert property (  // see RL5
    @(posedge mclk) disable iff (reset)
    secured_q && cpu_wr && hit_flash_control |=>
      row_program_select_q == $past(row_program_select_q))
    else $error("program select changed while secured");

  a_mass_write: assert property (  // see RL2
    @(posedge mclk) disable iff (reset)
    cpu_wr && hit_flash_control && !cpu_wdata[PROG_SEL_BIT] |=>
      mass_erase_select_q == $past(cpu_wdata[MASS_SEL_BIT]))
    else $error("mass erase select not written");

  a_pgm_write: assert property (  // see RL3
    @(posedge mclk) disable iff (reset)
    !secured_q && cpu_wr && hit_flash_control && !cpu_wdata[MASS_SEL_BIT] |=>
      row_program_select_q == $past(cpu_wdata[PROG_SEL_BIT]))
    else $error("program select not written");

  a_window_page: assert property (  // see RL6, RL7, RL8, RL12
    @(posedge mclk) disable iff (reset)
    (cpu_wr || cpu_rd) && fpw_in_window(cpu_addr) && !hit_flash_control &&
      !hit_psel |=>
      mem_req_q.addr == {$past(page_sel_q), $past(cpu_addr[5:0])})
    else $error("window address not paged");

  a_indirect_alias: assert property (  // see RL10, RL11
    @(posedge mclk) disable iff (reset)
    cpu_rd && cpu_addr == INDIRECT_ADDR && page_sel_q == 8'h00 &&
      (index_value == 8'h0E || index_value == 8'hCE) |=>
      mem_req_q.rd && mem_req_q.addr == INDIRECT_ADDR)
    else $error("indirect data did not reach RAM $000E");

  a_window_index: assert property (  // see RL9
    @(posedge mclk) disable iff (reset)
    cpu_rd && cpu_addr == 14'h00CF && page_sel_q == 8'h00 |=>
      mem_req_q.addr == 14'h000F)
    else $error("window $CF did not reach index register");

  a_hv_cleared_off: assert property (  // see RL1
    @(posedge mclk) disable iff (reset)
    cpu_wr && hit_flash_control && !cpu_wdata[HV_ON_BIT] |=>
      !array_high_voltage_on_q)
    else $error("high voltage not cleared");

  // Must hold through reset, so no disable here
  a_secure_capture: assert property (  // see RL14
    @(posedge mclk)
    reset |=> secured_q == !$past(security_state_bit))
    else $error("security copy not taken at reset");

  // The live bit may change after reset; the copy must not follow it
  a_secure_hold: assert property (  // see RL14
    @(posedge mclk) disable iff (reset)
    $stable(secured_q))
    else $error("security copy changed outside reset");

  a_ctl_readback: assert property (  // see RL2, RL3
    @(posedge mclk) disable iff (reset)
    cpu_rd && hit_flash_control |=> reg_rvalid_q &&
      reg_rdata_q == {4'h0, $past(array_high_voltage_on_q),
                      $past(mass_erase_select_q), 1'b0,
                      $past(row_program_select_q)})
    else $error("flash control read back wrong");

  a_page_readback: assert property (  // see RL7
    @(posedge mclk) disable iff (reset)
    cpu_rd && hit_psel |=>
      reg_rvalid_q && reg_rdata_q == $past(page_sel_q))
    else $error("page selector read back wrong");

endmodule // fpw_flash_ctrl

// File: design/fpw_pkg.sv
// Package for the flash control and direct-page paging window block.
// Assumes a 14-bit byte address map and an 8-bit data path.
package fpw_pkg;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;

  // Window and aliasing addresses
  localparam logic [13:0] WINDOW_BASE     = 14'h00C0;
  localparam logic [13:0] WINDOW_LAST     = 14'h00FF;
  localparam logic [13:0] INDIRECT_ADDR   = 14'h000E;
  localparam logic [13:0] FLASH_BASE      = 14'h1000;
  localparam int          PAGE_OFS_W      = 6;

  // Register addresses
  localparam logic [13:0] PAGE_SELECTOR_ADDR = 14'h001F;
  localparam logic [13:0] FLASH_CONTROL_ADDR = 14'h0210;

  // Field positions in the flash control register
  localparam int HV_ON_BIT    = 3;
  localparam int MASS_SEL_BIT = 2;
  localparam int PROG_SEL_BIT = 0;

  // Reset values
  localparam logic [7:0] FLASH_CONTROL_RST = 8'h00;
  localparam logic [7:0] PAGE_SELECTOR_RST = 8'h00;

  typedef struct packed {
    logic [13:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } fpw_mem_req_t;

  function automatic logic fpw_in_window(input logic [13:0] a);
    return (a >= WINDOW_BASE) && (a <= WINDOW_LAST);
  endfunction

endpackage

// File: design/fpw_window_map.sv
// Address translation for the direct-page paging window and indirect data.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module fpw_window_map
  import fpw_pkg::*;
(
  input  wire logic [13:0] cpu_addr,
  input  wire logic [7:0]  page_sel,
  input  wire logic [7:0]  index_value,
  output logic      [13:0] phys_addr,
  output logic             via_window
);

  logic [13:0] eff_addr;

  always_comb begin
    // Indirect data register lives at $000E only; it points through the index
    if (cpu_addr == INDIRECT_ADDR) begin  // see RL10
      eff_addr = {6'h00, index_value};
    end else begin
      eff_addr = cpu_addr;
    end
    via_window = fpw_in_window(eff_addr);
    // Page bits form address bits 13..6, offset bits 5..0
    if (via_window) begin  // see RL6, RL7, RL8, RL12
      phys_addr = {page_sel, eff_addr[PAGE_OFS_W-1:0]};
    end else begin
      phys_addr = eff_addr;
    end
  end

endmodule // fpw_window_map

// File: testbench/tb_top.sv
// Self-checking bench for the flash control and paging window block.
// Assumes fpw_pkg and fpw_flash_ctrl are compiled first.
`timescale 1ns/1ps
module tb_top;
  import fpw_pkg::*;
  logic         mclk;
  logic         reset;
  logic [13:0]  cpu_addr;
  logic         cpu_wr;
  logic         cpu_rd;
  logic [7:0]   cpu_wdata;
  logic [7:0]   index_value;
  logic         security_state_bit;
  fpw_mem_req_t mem_req_q;
  logic [7:0]   reg_rdata_q;
  logic         reg_rvalid_q;
  logic         pgm_q;
  logic         mass_q;
  logic         hv_q;
  logic         secured_q;
  int           failures;
  int           tests_run;

  fpw_flash_ctrl i_dut (
    .mclk(mclk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .index_value(index_value),
    .security_state_bit(security_state_bit), .mem_req_q(mem_req_q),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .row_program_select_q(pgm_q), .mass_erase_select_q(mass_q),
    .array_high_voltage_on_q(hv_q), .secured_q(secured_q)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // One access: held for the taking edge, answer sampled after it lands
  task automatic op(input logic [13:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr  <= a;
    cpu_wr    <= w;
    cpu_rd    <= !w;
    cpu_wdata <= d;
    @(posedge mclk);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic sec);
    @(posedge mclk);
    reset              <= 1'b1;
    security_state_bit <= sec;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk("secured", {15'h0000, secured_q}, {15'h0000, !sec});
  endtask

  // Write control, check the level outputs, then read it back
  task automatic flash_control(input logic [7:0] w, input logic [7:0] exp);
    op(FLASH_CONTROL_ADDR, 1'b1, w);
    chk("selects", {12'h000, hv_q, mass_q, 1'b0, pgm_q}, {8'h00, exp});
    op(FLASH_CONTROL_ADDR, 1'b0, 8'h00);
    chk("ctl read", {7'h00, reg_rvalid_q, reg_rdata_q}, {8'h01, exp});
  endtask

  task automatic win_rd(input logic [13:0] a, input logic [13:0] exp);
    op(a, 1'b0, 8'h00);
    chk("mem req", {1'b0, mem_req_q.rd, mem_req_q.addr}, {2'b01, exp});
  endtask

  task automatic t_window();
    logic [7:0]  pg [5] = '{8'h00, 8'h00, 8'h05, 8'h40, 8'hFF};
    logic [13:0] of [5] = '{14'h00C3, 14'h00FF, 14'h00C0, 14'h00C0, 14'h00FF};
    logic [13:0] ex [5] = '{14'h0003, 14'h003F, 14'h0140, 14'h1000, 14'h3FFF};
    for (int i = 0; i < 5; i++) begin
      op(PAGE_SELECTOR_ADDR, 1'b1, pg[i]);
      chk("sel quiet", {14'h0000, mem_req_q.wr, mem_req_q.rd}, 16'h0000);
      win_rd(of[i], ex[i]);
    end
    op(PAGE_SELECTOR_ADDR, 1'b0, 8'h00);
    chk("page read", {7'h00, reg_rvalid_q, reg_rdata_q}, 16'h01FF);
    win_rd(14'h00BF, 14'h00BF);
    op(PAGE_SELECTOR_ADDR, 1'b1, 8'h08);
    op(14'h00D0, 1'b0, 8'h00);
    chk("page 08", {7'h00, reg_rvalid_q, reg_rdata_q}, 16'h0100);
  endtask

  task automatic t_indirect();
    op(PAGE_SELECTOR_ADDR, 1'b1, 8'h00);
    index_value <= 8'hCE;
    win_rd(INDIRECT_ADDR, 14'h000E);
    index_value <= 8'h0E;
    win_rd(INDIRECT_ADDR, 14'h000E);
    index_value <= 8'h22;
    win_rd(INDIRECT_ADDR, 14'h0022);
    win_rd(14'h00CE, 14'h000E);
    win_rd(14'h00CF, 14'h000F);
  endtask

  task automatic t_control();
    flash_control(8'h05, 8'h04);
    flash_control(8'h01, 8'h01);
    flash_control(8'h05, 8'h01);
    flash_control(8'h09, 8'h01);
    op(PAGE_SELECTOR_ADDR, 1'b1, 8'h40);
    op(14'h00C0, 1'b1, 8'hA5);
    chk("row wr", {1'b0, mem_req_q.wr, mem_req_q.addr}, 16'h5000);
    chk("row data", {8'h00, mem_req_q.wdata}, 16'h00A5);
    flash_control(8'h09, 8'h09);
    flash_control(8'h08, 8'h08);
    flash_control(8'h00, 8'h00);
    flash_control(8'h04, 8'h04);
    flash_control(8'h0C, 8'h04);
    flash_control(8'h00, 8'h00);
  endtask

  task automatic t_secure();
    do_reset(1'b0);
    security_state_bit <= 1'b1;
    flash_control(8'h01, 8'h00);
    chk("secured hold", {15'h0000, secured_q}, 16'h0001);
    flash_control(8'h04, 8'h04);
    flash_control(8'h00, 8'h00);
    do_reset(1'b1);
    flash_control(8'h01, 8'h01);
  endtask

  initial begin
    #20000;
    failures++;
    end_sim();
  end

  initial begin
    failures           = 0;
    tests_run          = 0;
    reset              = 1'b1;
    cpu_addr           = 14'h0000;
    cpu_wr             = 1'b0;
    cpu_rd             = 1'b0;
    cpu_wdata          = 8'h00;
    index_value        = 8'h00;
    security_state_bit = 1'b1;
    do_reset(1'b1);
    flash_control(8'h00, 8'h00);
    t_window();
    t_indirect();
    t_control();
    t_secure();
    end_sim();
  end
endmodule // tb_top
